// [rtl/cpvu_core.sv]
// Stack pointer, data pointer, vector and program memory map logic
// Functional notes
// - Every reset loads the program counter with address zero.
// - 0x0003-0x0093 is vector area; 0x0001-0x0002 is plain code.
// - Interrupt entry jumps to the fixed vector of its source.
// - Self-programming allowed only in 0x0094 to 0x1FBF.
// - Protected external program reads return 0x00.
// - One 16-bit data pointer from high and low bytes.
// - Auto stepping updates the pointer after each pointer external move.
// - Step select bits 2:1: +1, -1, +2, -2; reset 00.
// - Bit 0 enables stepping, resets 0; bits 7:3 read zero.
// - Stack pointer resets to 0x07 and is software writable.
// - Push adds one; call and interrupt entry add two.
// - Pop subtracts one; return subtracts two.
// - Registers at addresses ending in 0 or 8 are bit accessible.
// - Registers live at 0x80-0xFF, direct addressing only.
`include "cpvu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpvu_core
   import cpvu_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Special function register port, direct addressing only
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_direct_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   output logic sfr_bit_ok_o,
   // Stack operations
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic call_i,
   input wire logic ret_i,
   output logic [7:0] stack_wr_addr_o,
   output logic [7:0] stack_rd_addr_o,
   // External RAM and table reads
   input wire logic ext_move_i,
   input wire logic table_read_i,
   output logic [15:0] data_pointer_o,
   // Program counter and vectors
   input wire logic pc_load_i,
   input wire logic [15:0] pc_next_i,
   input wire logic irq_take_i,
   input wire logic [3:0] irq_src_i,
   output logic [15:0] pc_o,
   output logic in_vector_area_o,
   // Self-programming and protection
   input wire logic [15:0] isp_addr_i,
   output logic isp_allowed_o,
   input wire logic protect_i,
   input wire logic rom_dump_i,
   input wire logic [7:0] rom_byte_i,
   output logic [7:0] rom_dump_data_o
);
   cpvu_state_t r;
   cpvu_state_t next_r;
   logic prot_meta;
   logic prot_sync;

   function automatic logic [15:0] vec_of(input logic [3:0] src);
      unique case (src)
         CPVU_SRC_EXT0: vec_of = `CPVU_VEC_EXT0;
         CPVU_SRC_TMR0: vec_of = `CPVU_VEC_TMR0;
         CPVU_SRC_EXT1: vec_of = `CPVU_VEC_EXT1;
         CPVU_SRC_TMR1: vec_of = `CPVU_VEC_TMR1;
         CPVU_SRC_SER: vec_of = `CPVU_VEC_SER;
         CPVU_SRC_TMR2: vec_of = `CPVU_VEC_TMR2;
         CPVU_SRC_TWI: vec_of = `CPVU_VEC_TWI;
         CPVU_SRC_SSP: vec_of = `CPVU_VEC_SSP;
         CPVU_SRC_CMP0: vec_of = `CPVU_VEC_CMP0;
         CPVU_SRC_CMP1: vec_of = `CPVU_VEC_CMP1;
         CPVU_SRC_CMP2: vec_of = `CPVU_VEC_CMP2;
         CPVU_SRC_CMP3: vec_of = `CPVU_VEC_CMP3;
         CPVU_SRC_PWM: vec_of = `CPVU_VEC_PWM;
         CPVU_SRC_ADC: vec_of = `CPVU_VEC_ADC;
         // Unused source codes fall back to the reset vector
         default: vec_of = `CPVU_RESET_VEC;
      endcase
   endfunction

   // Pointer wraps modulo 2^16; no carry leaves the block
   function automatic logic [15:0] step_of(input logic [15:0] dp, input cpvu_step_t sel);
      unique case (sel)
         CPVU_STEP_INC1: step_of = dp + 16'h0001;
         CPVU_STEP_DEC1: step_of = dp - 16'h0001;
         CPVU_STEP_INC2: step_of = dp + 16'h0002;
         CPVU_STEP_DEC2: step_of = dp - 16'h0002;
      endcase
   endfunction

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic sfr_sel;
   logic [15:0] dp_now;
   logic [15:0] dp_step;
   assign sfr_sel = sfr_direct_i && sfr_addr_i[7];
   assign dp_now = {r.data_pointer_high, r.data_pointer_low};
   assign dp_step = step_of(dp_now, r.auto_step_select);

   // One decoded hit per mapped register, shared by write and hit flag
   logic hit_stack;
   logic hit_dpl;
   logic hit_dph;
   logic hit_step;
   assign hit_stack = sfr_sel && (sfr_addr_i == `CPVU_SFR_STACK);
   assign hit_dpl = sfr_sel && (sfr_addr_i == `CPVU_SFR_DPL);
   assign hit_dph = sfr_sel && (sfr_addr_i == `CPVU_SFR_DPH);
   assign hit_step = sfr_sel && (sfr_addr_i == `CPVU_SFR_STEP);

   // Write strobes; unmapped addresses are silently ignored
   logic wr_stack;
   logic wr_dpl;
   logic wr_dph;
   logic wr_step;
   assign wr_stack = hit_stack && sfr_wr_i;
   assign wr_dpl = hit_dpl && sfr_wr_i;
   assign wr_dph = hit_dph && sfr_wr_i;
   assign wr_step = hit_step && sfr_wr_i;

   always_comb begin
      next_r = r;
      // Stack: push/call pre-increment, pop/ret post-decrement
      if (push_i) begin
         next_r.stack_top_pointer = r.stack_top_pointer + 8'h01;
      end else if (call_i || irq_take_i) begin
         next_r.stack_top_pointer = r.stack_top_pointer + 8'h02;
      end else if (pop_i) begin
         next_r.stack_top_pointer = r.stack_top_pointer - 8'h01;
      end else if (ret_i) begin
         next_r.stack_top_pointer = r.stack_top_pointer - 8'h02;
      end
      // Table reads deliberately absent: they never step the pointer
      if (ext_move_i && r.auto_step_enable && !table_read_i) begin
         next_r.data_pointer_high = dp_step[15:8];
         next_r.data_pointer_low = dp_step[7:0];
      end
      // Software writes win over automatic updates in the same cycle
      if (wr_stack) begin
         next_r.stack_top_pointer = sfr_wdata_i;
      end
      if (wr_dpl) begin
         next_r.data_pointer_low = sfr_wdata_i;
      end
      if (wr_dph) begin
         next_r.data_pointer_high = sfr_wdata_i;
      end
      if (wr_step) begin
         next_r.auto_step_enable = sfr_wdata_i[`CPVU_STEP_EN_BIT];
         next_r.auto_step_select = cpvu_step_t'(sfr_wdata_i[`CPVU_STEP_SEL_MSB:`CPVU_STEP_SEL_LSB]);
      end

      // Interrupt entry beats a plain load in the same cycle
      if (irq_take_i) begin
         next_r.pc = vec_of(irq_src_i);
      end else if (pc_load_i) begin
         next_r.pc = pc_next_i;
      end
      // Protected dumps never expose the stored byte
      next_r.rom_rdata = r.rom_rdata;
      if (rom_dump_i) begin
         next_r.rom_rdata = prot_sync ? `CPVU_PROT_BYTE : rom_byte_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         r.stack_top_pointer <= `CPVU_STACK_RST;
         r.data_pointer_low <= `CPVU_DP_RST;
         r.data_pointer_high <= `CPVU_DP_RST;
         r.auto_step_enable <= 1'(`CPVU_STEP_RST >> `CPVU_STEP_EN_BIT);
         r.auto_step_select <= CPVU_STEP_INC1;
         r.pc <= `CPVU_RESET_VEC;
         r.rom_rdata <= `CPVU_PROT_BYTE;
         prot_meta <= 1'b1;
         prot_sync <= 1'b1;
      end else begin
         r <= next_r;
         // Protection option is a strap from outside; default to protected
         // Only the second stage is read, so a metastable first stage never leaks
         prot_meta <= protect_i;
         prot_sync <= prot_meta;
      end
   end

   always_comb begin
      sfr_rdata_o = 8'h00;
      if (sfr_sel) begin
         unique case (sfr_addr_i)
            `CPVU_SFR_STACK: sfr_rdata_o = r.stack_top_pointer;
            `CPVU_SFR_DPL: sfr_rdata_o = r.data_pointer_low;
            `CPVU_SFR_DPH: sfr_rdata_o = r.data_pointer_high;
            `CPVU_SFR_STEP: sfr_rdata_o = {5'h00, r.auto_step_select, r.auto_step_enable};
            default: sfr_rdata_o = 8'h00;
         endcase
      end
   end


   assign sfr_hit_o = hit_stack || hit_dpl || hit_dph || hit_step;
   assign sfr_bit_ok_o = sfr_sel && ((sfr_addr_i & `CPVU_BIT_ADDR_MASK) == 8'h00);
   assign stack_wr_addr_o = r.stack_top_pointer + 8'h01;
   assign stack_rd_addr_o = r.stack_top_pointer;
   assign data_pointer_o = dp_now;
   assign pc_o = r.pc;
   assign in_vector_area_o = in_range(r.pc, `CPVU_VEC_AREA_LO, `CPVU_VEC_AREA_HI);
   // Top area blocked here too, so a software slip cannot corrupt it
   assign isp_allowed_o = in_range(isp_addr_i, `CPVU_ISP_LO, `CPVU_ISP_HI);
   assign rom_dump_data_o = r.rom_rdata;
endmodule
`default_nettype wire

// [rtl/cpvu_regs.svh]
// Register offsets, reset values, field positions and memory map limits
`ifndef CPVU_REGS_SVH
`define CPVU_REGS_SVH
`define CPVU_SFR_STACK 8'h81
`define CPVU_SFR_DPL 8'h82
`define CPVU_SFR_DPH 8'h83
`define CPVU_SFR_STEP 8'h93
`define CPVU_SFR_BASE 8'h80
`define CPVU_STACK_RST 8'h07
`define CPVU_DP_RST 8'h00
`define CPVU_STEP_RST 3'h0
`define CPVU_STEP_EN_BIT 0
`define CPVU_STEP_SEL_LSB 1
`define CPVU_STEP_SEL_MSB 2
`define CPVU_RESET_VEC 16'h0000
`define CPVU_VEC_AREA_LO 16'h0003
`define CPVU_VEC_AREA_HI 16'h0093
`define CPVU_ISP_LO 16'h0094
`define CPVU_ISP_HI 16'h1FBF
`define CPVU_PROT_BYTE 8'h00
`define CPVU_BIT_ADDR_MASK 8'h07
`define CPVU_VEC_EXT0 16'h0003
`define CPVU_VEC_TMR0 16'h000B
`define CPVU_VEC_EXT1 16'h0013
`define CPVU_VEC_TMR1 16'h001B
`define CPVU_VEC_SER 16'h0023
`define CPVU_VEC_TMR2 16'h002B
`define CPVU_VEC_TWI 16'h0043
`define CPVU_VEC_SSP 16'h004B
`define CPVU_VEC_CMP0 16'h0053
`define CPVU_VEC_CMP1 16'h005B
`define CPVU_VEC_CMP2 16'h0063
`define CPVU_VEC_CMP3 16'h006B
`define CPVU_VEC_PWM 16'h0083
`define CPVU_VEC_ADC 16'h008B
`endif

// [rtl/cpvu_pkg.sv]
// Types for the pointer and vector unit
package cpvu_pkg;
   typedef enum logic [3:0] {
      CPVU_SRC_EXT0 = 4'h0, CPVU_SRC_TMR0 = 4'h1, CPVU_SRC_EXT1 = 4'h2, CPVU_SRC_TMR1 = 4'h3,
      CPVU_SRC_SER = 4'h4, CPVU_SRC_TMR2 = 4'h5, CPVU_SRC_TWI = 4'h6, CPVU_SRC_SSP = 4'h7,
      CPVU_SRC_CMP0 = 4'h8, CPVU_SRC_CMP1 = 4'h9, CPVU_SRC_CMP2 = 4'hA, CPVU_SRC_CMP3 = 4'hB,
      CPVU_SRC_PWM = 4'hC, CPVU_SRC_ADC = 4'hD
   } cpvu_src_t;
   typedef enum logic [1:0] {
      CPVU_STEP_INC1 = 2'h0, CPVU_STEP_DEC1 = 2'h1, CPVU_STEP_INC2 = 2'h2, CPVU_STEP_DEC2 = 2'h3
   } cpvu_step_t;
   typedef struct packed {
      logic [7:0] stack_top_pointer;
      logic [7:0] data_pointer_low;
      logic [7:0] data_pointer_high;
      logic auto_step_enable;
      cpvu_step_t auto_step_select;
      logic [15:0] pc;
      logic [7:0] rom_rdata;
   } cpvu_state_t;
endpackage

// [sim/cpvu_core_checker.sv]
// Checker for the pointer and vector unit
`timescale 1ns/1ps
`default_nettype none
module cpvu_core_checker (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_direct_i,
   input wire logic sfr_bit_ok_o,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic call_i,
   input wire logic irq_take_i,
   input wire logic [7:0] stack_wr_addr_o,
   input wire logic [7:0] stack_rd_addr_o,
   input wire logic ext_move_i,
   input wire logic table_read_i,
   input wire logic sfr_wr_i,
   input wire logic [15:0] data_pointer_o,
   input wire logic [15:0] pc_o,
   input wire logic in_vector_area_o,
   input wire logic [15:0] isp_addr_i,
   input wire logic isp_allowed_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   a_pc_reset_zero: assert property
      ($rose(nrst_i) |-> pc_o == 16'h0000) else $error("pc not zero after reset");
   a_vector_area_flag: assert property
      (in_vector_area_o == (pc_o >= 16'h0003 && pc_o <= 16'h0093)) else $error("vector area flag");
   a_isp_window_gate: assert property
      (isp_allowed_o == (isp_addr_i >= 16'h0094 && isp_addr_i <= 16'h1FBF)) else $error("isp window");
   a_push_adds_one: assert property
      (push_i |=> stack_rd_addr_o == $past(stack_rd_addr_o) + 8'h01) else $error("push step");
   a_call_adds_two: assert property
      (call_i && !push_i |=> stack_rd_addr_o == $past(stack_rd_addr_o) + 8'h02) else $error("call step");
   a_pop_subs_one: assert property
      (pop_i && !(push_i || call_i || irq_take_i) |=> stack_rd_addr_o == $past(stack_rd_addr_o) - 8'h01)
      else $error("pop step");
   a_push_target_ahead: assert property
      (stack_wr_addr_o == stack_rd_addr_o + 8'h01) else $error("push target");
   a_table_keeps_pointer: assert property
      (table_read_i && !sfr_wr_i |=> $stable(data_pointer_o)) else $error("table read stepped pointer");
   a_bit_access_ok: assert property
      (sfr_bit_ok_o == (sfr_direct_i && sfr_addr_i[7] && sfr_addr_i[2:0] == 3'h0)) else $error("bit access flag");
   c_push: cover property (push_i);
   c_move: cover property (ext_move_i && !table_read_i);
   c_irq: cover property (irq_take_i);
endmodule
bind cpvu_core cpvu_core_checker u_chk (.*);
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the pointer and vector unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top;
   logic mclk_i = 1'b0, nrst_i = 1'b0, sfr_direct_i = 1'b1, sfr_wr_i = 1'b0, push_i = 1'b0, pop_i = 1'b0;
   logic call_i = 1'b0, ret_i = 1'b0, ext_move_i = 1'b0, table_read_i = 1'b0, pc_load_i = 1'b0;
   logic irq_take_i = 1'b0, protect_i = 1'b1, rom_dump_i = 1'b0, sfr_hit_o, sfr_bit_ok_o, in_vector_area_o, isp_allowed_o;
   logic [7:0] sfr_addr_i = 8'h80, sfr_wdata_i = 8'h00, rom_byte_i = 8'hA5;
   logic [7:0] sfr_rdata_o, stack_wr_addr_o, stack_rd_addr_o, rom_dump_data_o;
   logic [15:0] pc_next_i = 16'h0001, isp_addr_i = 16'h0094, data_pointer_o, pc_o, exp;
   logic [15:0] vt [14] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0043,
      16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B, 16'h0083, 16'h008B};
   logic [15:0] step [4] = '{16'h0001, 16'hFFFF, 16'h0002, 16'hFFFE};
   logic [3:0] irq_src_i = 4'h0;
   int bad_count = 0;
   int n_tests = 0;
   cpvu_core u_dut (.*);
   always #12.5 mclk_i = ~mclk_i;
   task automatic cyc();
      @(negedge mclk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      cyc();
      sfr_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr_i = a;
      #1 `CHK("sfr read", e, sfr_rdata_o)
   endtask
   task automatic mv(input logic t);
      {ext_move_i, table_read_i} = {1'b1, t};
      cyc();
      {ext_move_i, table_read_i} = 2'b00;
   endtask
   task automatic st(input logic [3:0] v, input logic [7:0] e);
      {push_i, call_i, pop_i, ret_i} = v;
      cyc();
      {push_i, call_i, pop_i, ret_i} = 4'h0;
      `CHK("stack pointer", e, stack_rd_addr_o)
   endtask
   task automatic t_regs();
      `CHK("pc", 16'h0000, pc_o)
      rd(8'h81, 8'h07);
      rd(8'h83, 8'h00);
      rd(8'h93, 8'h00);
      rd(8'h84, 8'h00);
      `CHK("hit", 1'b0, sfr_hit_o)
      `CHK("bit access", 1'b0, sfr_bit_ok_o)
      rd(8'h88, 8'h00);
      `CHK("bit access", 1'b1, sfr_bit_ok_o)
      wr(8'h93, 8'hFE);
      rd(8'h93, 8'h06);
      `CHK("hit", 1'b1, sfr_hit_o)
      sfr_direct_i = 1'b0;
      rd(8'h81, 8'h00);
      sfr_direct_i = 1'b1;
   endtask
   task automatic t_dp();
      mv(1'b0);
      `CHK("pointer", 16'h0000, data_pointer_o)
      exp = 16'h0000;
      for (int i = 1; i < 5; i++) begin
         wr(8'h93, {5'h00, i[1:0], 1'b1});
         mv(1'b0);
         exp = exp + step[i % 4];
         `CHK("pointer", exp, data_pointer_o)
      end
      mv(1'b1);
      `CHK("pointer", exp, data_pointer_o)
      rd(8'h82, 8'h00);
   endtask
   task automatic t_stack();
      st(4'b1000, 8'h08);
      st(4'b0100, 8'h0A);
      st(4'b1010, 8'h0B);
      st(4'b0010, 8'h0A);
      st(4'b0001, 8'h08);
      wr(8'h81, 8'hBF);
      st(4'b1000, 8'hC0);
      `CHK("push target", 8'hC1, stack_wr_addr_o)
   endtask
   task automatic t_pc();
      for (int i = 0; i < 14; i++) begin
         irq_src_i = i[3:0];
         irq_take_i = 1'b1;
         cyc();
         irq_take_i = 1'b0;
         `CHK("vector", vt[i], pc_o)
      end
      `CHK("vector area", 1'b1, in_vector_area_o)
      `CHK("stack pointer", 8'hDC, stack_rd_addr_o)
      pc_load_i = 1'b1;
      cyc();
      pc_load_i = 1'b0;
      `CHK("vector area", 1'b0, in_vector_area_o)
      `CHK("isp low edge", 1'b1, isp_allowed_o)
      isp_addr_i = 16'h1FC0;
      #1 `CHK("isp top", 1'b0, isp_allowed_o)
   endtask
   task automatic t_prot(input logic p, input logic [7:0] e);
      protect_i = p;
      repeat (3) cyc();
      rom_dump_i = 1'b1;
      cyc();
      rom_dump_i = 1'b0;
      `CHK("dump", e, rom_dump_data_o)
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (5) cyc();
      nrst_i = 1'b1;
      cyc();
      t_regs();
      t_dp();
      t_stack();
      t_pc();
      t_prot(1'b1, 8'h00);
      t_prot(1'b0, 8'hA5);
      test_done();
   end
   initial begin
      repeat (2000) @(posedge mclk_i);
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire
